// ### motor_port_pkg.sv
/*
  Shared constants for the motor driver serial host port: frame layout,
  bit counts, control register addresses and field positions, DAC map
  addresses and the frame state type.
  Assumes it is compiled before every other file of the block.
*/
package motor_port_pkg;

  // Widths of the DAC store and of the serial frame counter.
  localparam int DAC_W = 12;
  localparam int DAC_DEPTH = 7;
  localparam int DAC_IDX_W = 3;
  localparam int CNT_W = 5;
  localparam int SYNC_W = 9;

  // Rising-edge counts that mark the header end, the frame end and the tolerance.
  localparam logic [4:0] CNT_HEADER = 5'h08;
  localparam logic [4:0] CNT_FRAME = 5'h10;
  localparam logic [4:0] CNT_MAX_OK = 5'h11;

  // Top two command bits that mark a control register frame.
  localparam logic [1:0] CTRL_PREFIX = 2'h3;
  // Value of the read/write flag that asks for a read.
  localparam logic RW_READ = 1'h1;

  // Control register addresses (seven bits, top two always set).
  localparam logic [6:0] A_DRIVER_ENA = 7'h70;
  localparam logic [6:0] A_FUNC_ENA = 7'h71;
  localparam logic [6:0] A_PARM0 = 7'h73;
  localparam logic [6:0] A_OPT_SET = 7'h74;
  localparam logic [6:0] A_WRITE_UNLOCK = 7'h76;
  localparam logic [6:0] A_CLEAR = 7'h77;
  localparam logic [6:0] A_MUTE_MON = 7'h79;
  localparam logic [6:0] A_VERSION = 7'h7E;
  localparam logic [6:0] A_STATUS = 7'h7F;

  // Field positions inside the control registers.
  localparam int B_TILT_EN = 7;
  localparam int B_FOCUS_EN = 6;
  localparam int B_TRACK_EN = 5;
  localparam int B_SPM_EN = 4;
  localparam int B_SLED_EN = 3;
  localparam int B_LOAD_EN = 1;
  localparam int B_CURRENT_SWITCH_ON = 3;
  localparam int B_MUTE_KEEP = 0;
  localparam int B_HALF_CH = 6;
  localparam int B_STAT_FOCUS = 5;
  localparam int B_EARLY_RD = 2;
  localparam int B_MAP_SEL = 0;
  localparam int B_UNLOCK = 7;
  localparam int B_CLR_ERR = 5;
  localparam int B_MUTE_SEEN = 5;
  localparam int B_PWR_ERR = 4;
  localparam int SLED_ZERO_BIT = 1;
  localparam int LOAD_MAP1_SHIFT = 4;

  // Register reset value.
  localparam logic [7:0] REG_RESET = 8'h00;

  // DAC frame addresses (top nibble of a DAC frame).
  localparam logic [3:0] DA_TILT = 4'h1;
  localparam logic [3:0] DA_FOCUS = 4'h2;
  localparam logic [3:0] DA_TRACK = 4'h3;
  localparam logic [3:0] DA_SLED1 = 4'h4;
  localparam logic [3:0] DA_SLED2 = 4'h5;
  localparam logic [3:0] DA_SPM_MAP1 = 4'h6;
  localparam logic [3:0] DA_SPM_MAP0 = 4'h8;
  localparam logic [3:0] DA_LOAD = 4'h9;

  // Word index of each DAC code inside the store.
  localparam logic [2:0] IX_TILT = 3'h0;
  localparam logic [2:0] IX_FOCUS = 3'h1;
  localparam logic [2:0] IX_TRACK = 3'h2;
  localparam logic [2:0] IX_SLED1 = 3'h3;
  localparam logic [2:0] IX_SLED2 = 3'h4;
  localparam logic [2:0] IX_SPM = 3'h5;
  localparam logic [2:0] IX_LOAD = 3'h6;

  // Frame tracking states.
  typedef enum logic [1:0] {F_IDLE, F_SHIFT, F_OVER} frame_state_t;

endpackage

// ### dac_store_if.sv
/*
  Carrier between the serial port and the DAC code store: one write port
  and one registered read port.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface dac_store_if #(parameter int AW = 3, parameter int DW = 12);
  logic wr_en; // One-cycle write strobe.
  logic [AW-1:0] wr_addr; // Word written.
  logic [DW-1:0] wr_data; // Code written.
  logic [AW-1:0] rd_addr; // Word read.
  logic [DW-1:0] rd_data; // Registered read data, one cycle late.
  modport port (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// ### dac_code_store.sv
/*
  Small memory for the write-only DAC codes, with a registered read port.
  Assumes writes arrive as single-cycle strobes from the serial port.
*/
`timescale 1ns/1ns
`default_nettype none
module dac_code_store #(
  parameter int DEPTH = 7,
  parameter int AW = 3,
  parameter int DW = 12
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  dac_store_if.store bus
);

  logic [DW-1:0] mem_r [DEPTH]; // Stored codes.
  logic [DW-1:0] mem_nxt [DEPTH]; // Next stored codes.
  logic [DW-1:0] rd_r; // Read data register.
  logic [DW-1:0] rd_nxt; // Next read data.

  // Writes land in the addressed word; out-of-range addresses read as zero.
  always_comb begin
    mem_nxt = mem_r;
    if (bus.wr_en && (int'(bus.wr_addr) < DEPTH)) begin
      mem_nxt[bus.wr_addr] = bus.wr_data;
    end
    rd_nxt = '0;
    if (int'(bus.rd_addr) < DEPTH) begin
      rd_nxt = mem_r[bus.rd_addr];
    end
  end

  // All codes return to zero at reset.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      rd_r <= '0;
    end else begin
      mem_r <= mem_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign bus.rd_data = rd_r;

endmodule
`default_nettype wire

// ### motor_driver_serial_host_port.sv
/*
  Serial slave port of a motor driver: frame capture, control registers,
  DAC code writes, read-back, mute handling and the ready/reset status.
  Assumes the host serial clock, select, data and all status inputs are
  asynchronous to i_clock, and that i_clock runs well above the serial clock.
*/
// How it works
// - Ready low while any serious event is present.
// - Converter drop latch: set below 80% while OVP is active, clear above 90%.
// - Mute falling clears drive and switch enables.
// - Mute clears loader enable only in half-channel mode.
// - Mute sets mute-seen and power-error flags.
// - Mute-keeps-enables bit blocks mute enable clearing.
// - Sixteen-bit frames count only while select low.
// - MSB first, shifted on rising serial clock.
// - Top bits 11 mean control, else DAC.
// - Discard frames with wrong serial clock count.
// - Valid write lands from sixteenth-edge capture.
// - All register bits reset to defaults.
// - Read data driven from eighth falling edge.
// - Early-read bit moves data half clock earlier.
// - Status returned during focus DAC write when enabled.
// - Writes blocked until write-unlock bit set.
// - Map zero DAC addresses as listed.
// - Map one swaps track/tilt, moves spindle, packs load.
// - Sled one bit one always stored zero.
// - Track and load share one converter.
`timescale 1ns/1ns
`default_nettype none
module motor_driver_serial_host_port #(
  parameter logic [7:0] VERSION_CODE = 8'hA5 // Arbitrary identification value.
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_sclk,
  input wire logic i_select_n,
  input wire logic i_host_to_device_data,
  input wire logic i_mute_in_n,
  input wire logic i_power_fail,
  input wire logic i_over_temp,
  input wire logic i_ovp_active,
  input wire logic i_conv_below_80,
  input wire logic i_conv_above_90,
  output logic o_ready_reset_out,
  output logic o_device_to_host_data,
  output logic o_device_to_host_data_oe,
  output logic o_tilt_drive_enable,
  output logic o_focus_drive_enable,
  output logic o_track_drive_enable,
  output logic o_spindle_drive_enable,
  output logic o_sled_drive_enable,
  output logic o_loader_drive_enable,
  output logic o_current_switch_on,
  output logic [motor_port_pkg::DAC_IDX_W-1:0] o_dac_index,
  output logic [motor_port_pkg::DAC_W-1:0] o_dac_code,
  output logic o_shared_serves_load
);
  import motor_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic [SYNC_W-1:0] sync1_r; // First synchroniser stage, read only by sync2_r.
  logic [SYNC_W-1:0] sync2_r; // Second synchroniser stage.
  logic s_sclk, s_sel_n, s_mosi, s_mute_n, s_pfail, s_otemp, s_ovp, s_lo80, s_hi90;

  logic prev_sclk_r, prev_sel_r, prev_mute_r; // Previous sampled levels for edges.
  frame_state_t state_r, state_nxt; // Frame tracking state.
  logic [CNT_W-1:0] count_r, count_nxt; // Rising edges seen in this frame.
  logic [15:0] shift_r, shift_nxt; // Incoming shift register.
  logic [15:0] frame_r, frame_nxt; // Copy taken at the sixteenth edge.
  logic [7:0] out_r, out_nxt; // Outgoing read data.
  logic armed_r, armed_nxt; // This frame returns data.
  logic dout_r, dout_nxt; // Serial output level.
  logic oe_r, oe_nxt; // Serial output enable.

  logic [7:0] drv_r, drv_nxt; // Driver enable register.
  logic [7:0] func_r, func_nxt; // Function enable register.
  logic [7:0] parm_r, parm_nxt; // Parameter register.
  logic [7:0] opt_r, opt_nxt; // Option register.
  logic unlock_r, unlock_nxt; // Write unlock bit.
  logic mute_seen_r, mute_seen_nxt; // Latched mute event.
  logic pwr_err_r, pwr_err_nxt; // Latched power error.
  logic drop_r, drop_nxt; // Converter output drop latch.
  logic ready_r, ready_nxt; // Ready/reset status.

  logic wr_en_r, wr_en_nxt; // DAC store write strobe.
  logic [DAC_IDX_W-1:0] wr_ix_r, wr_ix_nxt; // DAC store word.
  logic [DAC_W-1:0] wr_data_r, wr_data_nxt; // DAC store data.
  logic [DAC_IDX_W-1:0] scan_r, scan_nxt; // Refresh scan pointer.
  logic [DAC_IDX_W-1:0] scan_d_r; // Scan pointer aligned with read data.
  logic [DAC_IDX_W-1:0] dac_ix_r; // Index presented to the converters.
  logic [DAC_W-1:0] dac_code_r; // Code presented to the converters.
  logic serve_load_r, serve_load_nxt; // Shared converter owner.

  logic sclk_rise, sclk_fall, sel_rise, mute_fall, early;
  logic [6:0] caddr; // Control address of the captured frame.
  logic [7:0] hdr; // Header bits as they complete.
  logic [7:0] tx_data; // Data chosen for return.
  logic tx_valid; // Header asks for returned data.
  logic dac_hit; // DAC address maps to a word.
  logic [DAC_IDX_W-1:0] dac_ix; // Word for the DAC address.

  dac_store_if #(.AW(DAC_IDX_W), .DW(DAC_W)) store_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Status byte, shared by register read-back and the focus-write return.
  function automatic logic [7:0] status_byte(input logic perr);
    status_byte = REG_RESET;
    status_byte[B_PWR_ERR] = perr;
  endfunction

  // Control register read-back; unmapped addresses read zero.
  function automatic logic [7:0] reg_read(input logic [6:0] a);
    reg_read = REG_RESET;
    case (a)
      A_DRIVER_ENA: reg_read = drv_r;
      A_FUNC_ENA: reg_read = func_r;
      A_PARM0: reg_read = parm_r;
      A_OPT_SET: reg_read = opt_r;
      A_WRITE_UNLOCK: reg_read[B_UNLOCK] = unlock_r;
      A_MUTE_MON: reg_read[B_MUTE_SEEN] = mute_seen_r;
      A_VERSION: reg_read = VERSION_CODE;
      A_STATUS: reg_read = status_byte(pwr_err_r);
      default: reg_read = REG_RESET;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers. Every pin passes two flops before logic sees it.

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1_r <= '1;
      sync2_r <= '1;
    end else begin
      sync1_r <= {i_sclk, i_select_n, i_host_to_device_data, i_mute_in_n, i_power_fail,
                  i_over_temp, i_ovp_active, i_conv_below_80, i_conv_above_90};
      sync2_r <= sync1_r;
    end
  end

  assign {s_sclk, s_sel_n, s_mosi, s_mute_n, s_pfail, s_otemp, s_ovp, s_lo80, s_hi90} = sync2_r;

  // Edges of the sampled serial clock, select and mute.
  assign sclk_rise = s_sclk & ~prev_sclk_r;
  assign sclk_fall = ~s_sclk & prev_sclk_r;
  assign sel_rise = s_sel_n & ~prev_sel_r;
  assign mute_fall = ~s_mute_n & prev_mute_r;
  assign early = opt_r[B_EARLY_RD];
  assign caddr = frame_r[15:9];
  assign hdr = {shift_r[6:0], s_mosi};

  ////////////////////////////////////////////////////////////////////////////
  // DAC address decode: the map select bit picks one of two layouts.

  always_comb begin
    dac_hit = 1'b1;
    dac_ix = IX_TILT;
    case (frame_r[15:12])
      DA_TILT: dac_ix = opt_r[B_MAP_SEL] ? IX_TRACK : IX_TILT;
      DA_FOCUS: dac_ix = IX_FOCUS;
      DA_TRACK: dac_ix = opt_r[B_MAP_SEL] ? IX_TILT : IX_TRACK;
      DA_SLED1: dac_ix = IX_SLED1;
      DA_SLED2: dac_ix = IX_SLED2;
      DA_SPM_MAP1: begin
        dac_ix = IX_SPM;
        dac_hit = opt_r[B_MAP_SEL];
      end
      DA_SPM_MAP0: begin
        dac_ix = IX_SPM;
        dac_hit = ~opt_r[B_MAP_SEL];
      end
      DA_LOAD: dac_ix = IX_LOAD;
      default: dac_hit = 1'b0; // Unused addresses are dropped.
    endcase
  end

  // Data returned for a read header or a focus header with status enabled.
  always_comb begin
    tx_valid = 1'b0;
    tx_data = REG_RESET;
    if (hdr[7:6] == CTRL_PREFIX) begin
      tx_valid = (hdr[0] == RW_READ);
      tx_data = reg_read(hdr[7:1]);
    end else if (hdr[7:4] == DA_FOCUS && opt_r[B_STAT_FOCUS]) begin
      tx_valid = 1'b1;
      tx_data = status_byte(pwr_err_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state of the serial engine and the register file.

  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    shift_nxt = shift_r;
    frame_nxt = frame_r;
    out_nxt = out_r;
    armed_nxt = armed_r;
    dout_nxt = dout_r;
    oe_nxt = oe_r;
    drv_nxt = drv_r;
    func_nxt = func_r;
    parm_nxt = parm_r;
    opt_nxt = opt_r;
    unlock_nxt = unlock_r;
    mute_seen_nxt = mute_seen_r;
    pwr_err_nxt = pwr_err_r;
    wr_en_nxt = 1'b0;
    wr_ix_nxt = wr_ix_r;
    wr_data_nxt = wr_data_r;
    serve_load_nxt = serve_load_r;

    if (s_sel_n) begin
      // Select high: the frame is over and the output is released.
      state_nxt = F_IDLE;
      count_nxt = '0;
      armed_nxt = 1'b0;
      oe_nxt = 1'b0;
      // Commit only a frame of the accepted length.
      if (sel_rise && state_r == F_SHIFT && count_r >= CNT_FRAME && count_r <= CNT_MAX_OK) begin
        if (frame_r[15:14] == CTRL_PREFIX) begin
          if (frame_r[8] != RW_READ && ready_r && (unlock_r || caddr == A_WRITE_UNLOCK)) begin
            case (caddr)
              A_DRIVER_ENA: drv_nxt = frame_r[7:0];
              A_FUNC_ENA: func_nxt = frame_r[7:0];
              A_PARM0: parm_nxt = frame_r[7:0];
              A_OPT_SET: opt_nxt = frame_r[7:0];
              A_WRITE_UNLOCK: unlock_nxt = frame_r[B_UNLOCK];
              A_CLEAR: begin
                if (frame_r[B_CLR_ERR]) begin
                  mute_seen_nxt = 1'b0;
                  pwr_err_nxt = 1'b0;
                end
              end
              default: ; // Read-only and unmapped addresses ignore writes.
            endcase
          end
        end else if (dac_hit && ready_r && unlock_r) begin
          wr_en_nxt = 1'b1;
          wr_ix_nxt = dac_ix;
          wr_data_nxt = frame_r[DAC_W-1:0];
          if (dac_ix == IX_SLED1) begin
            wr_data_nxt[SLED_ZERO_BIT] = 1'b0;
          end
          if (dac_ix == IX_LOAD && opt_r[B_MAP_SEL]) begin
            wr_data_nxt = {frame_r[7:0], {LOAD_MAP1_SHIFT{1'b0}}};
          end
          // One converter serves track or load, whichever was written last.
          if (dac_ix == IX_TRACK) begin
            serve_load_nxt = 1'b0;
          end else if (dac_ix == IX_LOAD) begin
            serve_load_nxt = 1'b1;
          end
        end
      end
    end else begin
      if (state_r == F_IDLE) begin
        state_nxt = F_SHIFT;
      end
      if (sclk_rise && state_r != F_OVER) begin
        if (count_r == CNT_MAX_OK) begin
          state_nxt = F_OVER; // Too many clocks: the frame is lost.
        end else begin
          count_nxt = count_r + 1'b1;
          shift_nxt = {shift_r[14:0], s_mosi};
          if (count_r == CNT_FRAME - 1'b1) begin
            frame_nxt = {shift_r[14:0], s_mosi};
          end
          if (count_r == CNT_HEADER - 1'b1) begin
            armed_nxt = tx_valid;
            out_nxt = tx_data;
            if (early && tx_valid) begin
              oe_nxt = 1'b1;
              dout_nxt = tx_data[7];
              out_nxt = {tx_data[6:0], 1'b0};
            end
          end else if (early && armed_r && count_r >= CNT_HEADER && count_r < CNT_FRAME - 1'b1) begin
            dout_nxt = out_r[7];
            out_nxt = {out_r[6:0], 1'b0};
          end
        end
      end
      if (sclk_fall) begin
        if (count_r >= CNT_FRAME) begin
          oe_nxt = 1'b0;
        end else if (!early && armed_r && count_r >= CNT_HEADER) begin
          oe_nxt = 1'b1;
          dout_nxt = out_r[7];
          out_nxt = {out_r[6:0], 1'b0};
        end
      end
    end

    // Mute events: flags always latch and win over a clear.
    if (mute_fall) begin
      mute_seen_nxt = 1'b1;
      pwr_err_nxt = 1'b1;
      if (!parm_r[B_MUTE_KEEP]) begin
        drv_nxt[B_TILT_EN] = 1'b0;
        drv_nxt[B_FOCUS_EN] = 1'b0;
        drv_nxt[B_TRACK_EN] = 1'b0;
        drv_nxt[B_SPM_EN] = 1'b0;
        drv_nxt[B_SLED_EN] = 1'b0;
        func_nxt[B_CURRENT_SWITCH_ON] = 1'b0;
        if (opt_r[B_HALF_CH]) begin
          drv_nxt[B_LOAD_EN] = 1'b0;
        end
      end
    end

    // Protection re-arms whenever the device falls back into reset status.
    if (!ready_nxt) begin
      unlock_nxt = 1'b0;
    end
  end

  // Ready/reset status with the converter drop hysteresis.
  always_comb begin
    drop_nxt = drop_r;
    if (s_ovp && s_lo80) begin
      drop_nxt = 1'b1;
    end else if (s_hi90) begin
      drop_nxt = 1'b0;
    end
    ready_nxt = ~(s_pfail | s_otemp | drop_nxt);
    // Converter refresh scan walks every stored word in turn.
    scan_nxt = (scan_r == IX_LOAD) ? IX_TILT : scan_r + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers. Everything resets to its default.

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      prev_sclk_r <= 1'b0;
      prev_sel_r <= 1'b1;
      prev_mute_r <= 1'b1;
      state_r <= F_IDLE;
      count_r <= '0;
      shift_r <= '0;
      frame_r <= '0;
      out_r <= REG_RESET;
      armed_r <= 1'b0;
      dout_r <= 1'b0;
      oe_r <= 1'b0;
      drv_r <= REG_RESET;
      func_r <= REG_RESET;
      parm_r <= REG_RESET;
      opt_r <= REG_RESET;
      unlock_r <= 1'b0;
      mute_seen_r <= 1'b0;
      pwr_err_r <= 1'b0;
      drop_r <= 1'b0;
      ready_r <= 1'b0;
      wr_en_r <= 1'b0;
      wr_ix_r <= IX_TILT;
      wr_data_r <= '0;
      scan_r <= IX_TILT;
      scan_d_r <= IX_TILT;
      dac_ix_r <= IX_TILT;
      dac_code_r <= '0;
      serve_load_r <= 1'b0;
    end else begin
      prev_sclk_r <= s_sclk;
      prev_sel_r <= s_sel_n;
      prev_mute_r <= s_mute_n;
      state_r <= state_nxt;
      count_r <= count_nxt;
      shift_r <= shift_nxt;
      frame_r <= frame_nxt;
      out_r <= out_nxt;
      armed_r <= armed_nxt;
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
      drv_r <= drv_nxt;
      func_r <= func_nxt;
      parm_r <= parm_nxt;
      opt_r <= opt_nxt;
      unlock_r <= unlock_nxt;
      mute_seen_r <= mute_seen_nxt;
      pwr_err_r <= pwr_err_nxt;
      drop_r <= drop_nxt;
      ready_r <= ready_nxt;
      wr_en_r <= wr_en_nxt;
      wr_ix_r <= wr_ix_nxt;
      wr_data_r <= wr_data_nxt;
      scan_r <= scan_nxt;
      scan_d_r <= scan_r;
      dac_ix_r <= scan_d_r;
      dac_code_r <= store_bus.rd_data;
      serve_load_r <= serve_load_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // DAC code store. Read data lags the address by one cycle, hence scan_d_r.

  assign store_bus.wr_en = wr_en_r;
  assign store_bus.wr_addr = wr_ix_r;
  assign store_bus.wr_data = wr_data_r;
  assign store_bus.rd_addr = scan_r;

  dac_code_store #(
    .DEPTH(DAC_DEPTH),
    .AW(DAC_IDX_W),
    .DW(DAC_W)
  ) dac_code_store_i (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .bus(store_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flops.

  assign o_ready_reset_out = ready_r;
  assign o_device_to_host_data = dout_r;
  assign o_device_to_host_data_oe = oe_r;
  assign o_tilt_drive_enable = drv_r[B_TILT_EN];
  assign o_focus_drive_enable = drv_r[B_FOCUS_EN];
  assign o_track_drive_enable = drv_r[B_TRACK_EN];
  assign o_spindle_drive_enable = drv_r[B_SPM_EN];
  assign o_sled_drive_enable = drv_r[B_SLED_EN];
  assign o_loader_drive_enable = drv_r[B_LOAD_EN];
  assign o_current_switch_on = func_r[B_CURRENT_SWITCH_ON];
  assign o_dac_index = dac_ix_r;
  assign o_dac_code = dac_code_r;
  assign o_shared_serves_load = serve_load_r;

endmodule
`default_nettype wire

// ### host_master_model.sv
/* Host master model: sends frames MSB first and collects replies.
   Assumes a 160 ns serial clock that stands low outside frames. */
`timescale 1ns/1ns
`default_nettype none
module host_master_model (
  input wire logic i_clock,
  input wire logic i_miso,
  input wire logic i_miso_oe,
  output logic o_sclk,
  output logic o_select_n,
  output logic o_mosi
);
  logic oe_mid = 1'b0; // Output enable seen halfway through the eighth high phase.
  initial begin
    o_sclk = 1'b0;
    o_select_n = 1'b1;
    o_mosi = 1'b0;
  end
  // One frame of n pulses; reply bits are taken at rises 9 to 16.
  task automatic xfer(input logic [15:0] f, input int n, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge i_clock);
    #1;
    o_select_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      o_mosi = (i < 16) ? f[15-i] : 1'b0;
      #80 o_sclk = 1'b1;
      // A released line reads as the inverse of the last bit.
      if (i >= 8 && i < 16) rd = {rd[6:0], i_miso_oe ? i_miso : ~rd[0]};
      // Early mode drives after the eighth rise, normal mode only after the eighth fall.
      #40 if (i == 7) oe_mid = i_miso_oe;
      #40 o_sclk = 1'b0;
    end
    #80 o_select_n = 1'b1;
    o_mosi = ~o_mosi;
    #400;
  endtask
endmodule
`default_nettype wire

// ### motor_port_chk.sv
/* Checker of the motor port pins.
   Assumes one clock domain with an active-low asynchronous reset. */
`timescale 1ns/1ns
`default_nettype none
module motor_port_chk (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_select_n,
  input wire logic i_over_temp,
  input wire logic i_power_fail,
  input wire logic o_ready_reset_out,
  input wire logic o_device_to_host_data_oe,
  input wire logic o_tilt_drive_enable,
  input wire logic o_loader_drive_enable
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  chk_oe_idle: assert property (i_select_n [*5] |-> !o_device_to_host_data_oe)
    else $error("data pin driven outside frame");
  chk_oe_frame: assert property ($rose(o_device_to_host_data_oe) |-> !i_select_n)
    else $error("data pin driven without select");
  chk_ready_temp: assert property (i_over_temp [*4] |-> !o_ready_reset_out)
    else $error("ready with over temperature");
  chk_ready_pwr: assert property (i_power_fail [*4] |-> !o_ready_reset_out)
    else $error("ready with power failure");
  chk_ready_rise: assert property ($rose(o_ready_reset_out) |-> !i_over_temp && !i_power_fail)
    else $error("ready rose with fault");
  chk_tilt_lock: assert property ($rose(o_tilt_drive_enable) |-> o_ready_reset_out)
    else $error("write taken while not ready");
  chk_tilt_frame: assert property ($rose(o_tilt_drive_enable) |-> i_select_n && $past(i_select_n, 2))
    else $error("write taken inside frame");
  chk_load_lock: assert property ($rose(o_loader_drive_enable) |-> o_ready_reset_out && i_select_n)
    else $error("loader enable set out of turn");
endmodule
bind motor_driver_serial_host_port motor_port_chk motor_port_chk_i (.*);
`default_nettype wire

// ### motor_driver_serial_host_port_bench.sv
/* Bench of the motor port: frame tasks and checked sequences.
   Assumes the host model and the bound checker are compiled first. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
  $display("mismatch %0t got %h exp %h", $time, a, e); end end
module motor_driver_serial_host_port_bench;
  import motor_port_pkg::*;
  logic i_clock = 1'b0, i_rstn = 1'b0, i_sclk, i_select_n, i_host_to_device_data;
  logic i_mute_in_n = 1'b1, i_power_fail = 1'b0, i_over_temp = 1'b0, i_ovp_active = 1'b0;
  logic i_conv_below_80 = 1'b0, i_conv_above_90 = 1'b1, o_ready_reset_out;
  logic o_device_to_host_data, o_device_to_host_data_oe, o_tilt_drive_enable;
  logic o_focus_drive_enable, o_track_drive_enable, o_spindle_drive_enable;
  logic o_sled_drive_enable, o_loader_drive_enable, o_current_switch_on, o_shared_serves_load;
  logic [DAC_IDX_W-1:0] o_dac_index;
  logic [DAC_W-1:0] o_dac_code;
  logic [7:0] rd;
  int error_cnt = 0, n_tests = 0;
  always #5 i_clock = ~i_clock;
  motor_driver_serial_host_port motor_driver_serial_host_port_i (.*);
  host_master_model host_master_model_i (.i_clock(i_clock), .i_miso(o_device_to_host_data),
    .i_miso_oe(o_device_to_host_data_oe), .o_sclk(i_sclk), .o_select_n(i_select_n),
    .o_mosi(i_host_to_device_data));
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [15:0] f, input int n = 16);
    host_master_model_i.xfer(f, n, rd);
  endtask
  // Enables in order tilt, focus, track, spindle, sled, loader, switch.
  task automatic en(input logic [6:0] e);
    `CHK({o_tilt_drive_enable, o_focus_drive_enable, o_track_drive_enable,
      o_spindle_drive_enable, o_sled_drive_enable, o_loader_drive_enable,
      o_current_switch_on}, e)
  endtask
  // The code view cycles through the words, so wait for the wanted one.
  task automatic dac(input logic [2:0] ix, input logic [11:0] e);
    for (int k = 0; k < 20 && o_dac_index !== ix; k++) @(negedge i_clock);
    `CHK(o_dac_index, ix)
    `CHK(o_dac_code, e)
  endtask
  task automatic end_sim;
    $display("mismatches %0d of %0d compares", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge i_clock);
    #1 i_rstn = 1'b1;
    #100;
    `CHK(o_ready_reset_out, 1'b1)
    en(7'h00);
    wr(16'hE0FA);
    en(7'h00);
    wr(16'hEC80);
    wr(16'hE0FA);
    wr(16'hE208);
    en(7'h7F);
    wr(16'hE100);
    `CHK(rd, 8'hFA)
    `CHK(host_master_model_i.oe_mid, 1'b0)
    wr(16'hE000, 15);
    en(7'h7F);
    wr(16'hE000, 18);
    en(7'h7F);
    wr(16'h2ABC);
    dac(IX_FOCUS, 12'hABC);
    wr(16'h4FFF);
    dac(IX_SLED1, 12'hFFD);
    wr(16'h8123);
    wr(16'h6777);
    dac(IX_SPM, 12'h123);
    wr(16'hE801);
    wr(16'h1456);
    dac(IX_TRACK, 12'h456);
    `CHK(o_shared_serves_load, 1'b0)
    wr(16'h3789);
    dac(IX_TILT, 12'h789);
    wr(16'h6321);
    dac(IX_SPM, 12'h321);
    wr(16'h90AB);
    dac(IX_LOAD, 12'hAB0);
    `CHK(o_shared_serves_load, 1'b1)
    wr(16'hE805);
    wr(16'hE900);
    `CHK(rd, 8'h05)
    `CHK(host_master_model_i.oe_mid, 1'b1)
    i_mute_in_n = 1'b0;
    #100;
    en(7'h02);
    wr(16'hE825);
    wr(16'h2000);
    `CHK(rd[4], 1'b1)
    wr(16'hF300);
    `CHK(rd[5], 1'b1)
    i_mute_in_n = 1'b1;
    wr(16'hE601);
    wr(16'hE0FA);
    wr(16'hE208);
    i_mute_in_n = 1'b0;
    #100;
    en(7'h7F);
    i_over_temp = 1'b1;
    #100;
    `CHK(o_ready_reset_out, 1'b0)
    i_over_temp = 1'b0;
    i_power_fail = 1'b1;
    #100;
    `CHK(o_ready_reset_out, 1'b0)
    i_power_fail = 1'b0;
    i_ovp_active = 1'b1;
    i_conv_below_80 = 1'b1;
    i_conv_above_90 = 1'b0;
    #100;
    i_conv_below_80 = 1'b0;
    #100;
    `CHK(o_ready_reset_out, 1'b0)
    i_conv_above_90 = 1'b1;
    i_ovp_active = 1'b0;
    #100;
    `CHK(o_ready_reset_out, 1'b1)
    wr(16'hE000);
    en(7'h7F);
    // Half-channel loader mode: a mute now clears the loader enable as well.
    wr(16'hEC80);
    wr(16'hE600);
    wr(16'hE840);
    i_mute_in_n = 1'b1;
    #100;
    i_mute_in_n = 1'b0;
    #100;
    en(7'h00);
    wr(16'hEE20);
    wr(16'hF300);
    `CHK(rd[5], 1'b0)
    `CHK(o_device_to_host_data_oe, 1'b0)
    end_sim;
  end
  // Cuts a hang short well after the sequence should have ended.
  initial begin
    #600000;
    error_cnt++;
    end_sim;
  end
endmodule
`default_nettype wire
